// ===== verilog/sec_cmd_pkg.sv
// constants for the secure-erase and freeze-lock command block
package sec_cmd_pkg;
  // command opcodes
  localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
  localparam logic [7:0] OP_FREEZE     = 8'hf5;
  localparam logic [7:0] OP_SET_PW     = 8'hf1;
  localparam logic [7:0] OP_UNLOCK     = 8'hf2;
  localparam logic [7:0] OP_DISABLE_PW = 8'hf6;
  // device/head bits that must be one, and the drive select bit
  localparam int DEVHEAD_B7  = 7;
  localparam int DEVHEAD_B5  = 5;
  localparam int DEVHEAD_DRV = 4;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CMD    = 8'h00; // wr: [7:0] opcode, [15:8] device/head
  localparam logic [7:0] ADDR_PARAM  = 8'h04; // wr: one 16-bit parameter word
  localparam logic [7:0] ADDR_ERROR  = 8'h08; // rd: error flags
  localparam logic [7:0] ADDR_STATUS = 8'h0c; // rd: status flags
  localparam logic [7:0] ADDR_STATE  = 8'h10; // rd: lock/frozen/armed state
  localparam logic [7:0] ADDR_USERPW = 8'h14; // wr: load user pw word (index in [19:16])
  localparam logic [7:0] ADDR_MASTPW = 8'h18; // wr: load master pw word
  localparam logic [7:0] ADDR_LOCKEN = 8'h1c; // rw: lock function enable
  localparam logic [7:0] ADDR_ERTIME = 8'h20; // rd: identify word 89
  localparam logic [7:0] ADDR_NATMAX = 8'h24; // rw: native maximum block
  localparam logic [7:0] ADDR_HOSTMX = 8'h28; // rw: host maximum block (not used by erase)
  localparam logic [7:0] ADDR_DRIVE  = 8'h2c; // rw: this drive's select value
  // error flag positions
  localparam int ERR_ABORT_BIT = 2;
  localparam int ERR_IDNF_BIT  = 4;
  // status flag positions
  localparam int ST_ERR  = 0;
  localparam int ST_CORRECTED = 2;
  localparam int ST_DRQ       = 3;
  localparam int ST_SEEKDONE  = 4;
  localparam int ST_FAULT     = 5;
  localparam int ST_RDY  = 6;
  localparam int ST_BSY  = 7;
  // parameter block layout
  localparam int PB_IDENT_BIT   = 0;
  localparam int PB_ENHANCE_BIT = 1;
  localparam int PB_PW_FIRST    = 1;
  localparam int PB_PW_LAST     = 16;
  localparam int PB_WORDS       = 256;
  localparam int PW_WORDS       = 16;
  // identify word 89 default, arbitrary
  localparam logic [15:0] ERASE_TIME_DEF = 16'h0001;
  localparam logic [31:0] NATIVE_MAX_DEF = 32'h0000_00ff;
  localparam logic [31:0] FIRST_BLOCK    = 32'h0000_0000;
  localparam logic [7:0]  STATUS_RESET   = 8'h50;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  // command state machine, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_XFER  = 5'b00010,
    ST_CHECK = 5'b00100,
    ST_WIPE  = 5'b01000,
    ST_DONE  = 5'b10000
  } cmd_state_t;
endpackage

// ===== verilog/security_erase_freeze_cmds.sv
// secure-erase and freeze-lock command interpreter with ahb-lite registers
`timescale 1ns/1ns
// Functional notes
// R1: opcode f4h with dev/head bits decodes erase
// R2: erase blocks 0 to native maximum block
// R3: request one parameter sector before erasing
// R4: lock off plus user identifier aborts
// R5: lock on, password mismatch aborts
// R6: word0 bit0 selects master or user
// R7: only normal erase mode supported
// R8: write zeros, no verify, defect lists untouched
// R9: erase without preceding prepare aborts
// R10: erase done disables lock, master kept
// R11: lock off skips password comparison
// R12: erase time reported as identify word 89
// R13: opcode f5h freezes at once, no data
// R14: frozen rejects all security-changing commands
// R15: only power cycle leaves frozen state
// R16: host sends prepare f3h before erase
// R17: completion clears busy, fault, corrected; sets ready
// R18: erase errors use abort and not-found only
module security_erase_freeze_cmds (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    clkEn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic                         dataRequest,
  output logic                         wipeWrite,
  output logic      [31:0]             wipeBlock,
  input  wire logic                    wipeFailPin
);
  import sec_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic        rdValid_r;
  logic [31:0] rdData_r;
  logic        hreadyout_r;
  logic        hresp_r;
  wire         addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
  wire         wrGo      = wrPend_r && clkEn;
  wire [7:0]   aIdx      = haddr[7:0];

  // command, password and configuration state lives here
  cmd_state_t  state_r, stateNxt;
  logic [7:0]  errFlags_r, errNxt;
  logic [7:0]  statFlags_r, statNxt;
  logic        lockEn_r;
  logic        frozen_r;
  logic        armed_r;
  logic        isMaster_r;
  logic        enhanced_r;
  logic [8:0]  wordCnt_r;
  logic        pwMatch_r;
  logic [15:0] userPw_r [PW_WORDS];
  logic [15:0] mastPw_r [PW_WORDS];
  logic [31:0] nativeMax_r;
  logic [31:0] hostMax_r;
  logic [31:0] wipeBlock_r;
  logic        wipeWrite_r;
  logic        dataReq_r;
  logic        drive_r;
  logic        wipeFail;

  // a command write only counts when addressed to this drive with fixed bits set
  wire         cmdWr    = wrGo && wrAddr_r == ADDR_CMD;
  wire [7:0]   opcode   = hwdata[7:0];
  wire [7:0]   devHead  = hwdata[15:8];
  wire         forMe    = devHead[DEVHEAD_B7] && devHead[DEVHEAD_B5]
                          && devHead[DEVHEAD_DRV] == drive_r;
  wire         idle     = state_r == ST_IDLE;
  wire         isErase  = cmdWr && forMe && idle && opcode == OP_ERASE_UNIT; // R1
  wire         isPrep   = cmdWr && forMe && idle && opcode == OP_ERASE_PREP;
  wire         isFreeze = cmdWr && forMe && idle && opcode == OP_FREEZE;
  // opcodes that would change the lock function settings
  wire         isSecChg = cmdWr && forMe && idle && (opcode == OP_SET_PW
                          || opcode == OP_UNLOCK || opcode == OP_DISABLE_PW);
  wire         paramWr  = wrGo && wrAddr_r == ADDR_PARAM && state_r == ST_XFER;
  wire [3:0]   pwIdx    = 4'(wordCnt_r - 9'(PB_PW_FIRST));
  wire         inPw     = wordCnt_r >= 9'(PB_PW_FIRST) && wordCnt_r <= 9'(PB_PW_LAST);
  wire [15:0]  selPw    = isMaster_r ? mastPw_r[pwIdx] : userPw_r[pwIdx]; // R6
  wire         lastWord = wordCnt_r == 9'(PB_WORDS - 1);
  wire         lastBlk  = wipeBlock_r == nativeMax_r; // R2

  // register write strobes, all taken in the data phase
  wire         lockWr   = wrGo && wrAddr_r == ADDR_LOCKEN;
  wire         userPwWr = wrGo && wrAddr_r == ADDR_USERPW && !frozen_r;
  wire         mastPwWr = wrGo && wrAddr_r == ADDR_MASTPW && !frozen_r;
  wire         natMaxWr = wrGo && wrAddr_r == ADDR_NATMAX && idle;
  wire         hostMaxWr = wrGo && wrAddr_r == ADDR_HOSTMX;
  wire         driveWr  = wrGo && wrAddr_r == ADDR_DRIVE;

  // status after a command ends: ready and seek complete, error summary valid
  function automatic logic [7:0] endStatus(input logic err);
    logic [7:0] s;
    s = '0;
    s[ST_RDY]       = 1'b1; // R17
    s[ST_SEEKDONE]  = 1'b1; // R17
    s[ST_ERR]       = err;  // R17
    s[ST_BSY]       = 1'b0; // R17
    s[ST_FAULT]     = 1'b0; // R17
    s[ST_CORRECTED] = 1'b0; // R17
    return s;
  endfunction

  // abort error byte, optionally with the not-found flag
  function automatic logic [7:0] abortErr(input logic idnf);
    logic [7:0] e;
    e = '0;
    e[ERR_ABORT_BIT] = 1'b1; // R18
    e[ERR_IDNF_BIT]  = idnf; // R18
    return e;
  endfunction

  // wipe failure input is a pin from the media side
  logic wipeFailS1_r, wipeFailS2_r;
  assign wipeFail = wipeFailS2_r;

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing
  always_comb begin
    stateNxt = state_r;
    errNxt   = errFlags_r;
    statNxt  = statFlags_r;
    case (state_r)
      ST_IDLE: begin
        if (isErase) begin
          errNxt  = '0;
          if (frozen_r || !armed_r) begin // R14 R9
            errNxt  = abortErr(1'b0);
            statNxt = endStatus(1'b1);
          end else begin
            stateNxt = ST_XFER; // R3
            statNxt  = '0;
            statNxt[ST_BSY] = 1'b0;
            statNxt[ST_DRQ] = 1'b1; // R3
          end
        end else if (isFreeze) begin
          errNxt  = '0;
          statNxt = endStatus(1'b0); // R13
        end else if (isSecChg && frozen_r) begin
          errNxt  = abortErr(1'b0); // R14
          statNxt = endStatus(1'b1);
        end else if (isPrep) begin
          errNxt  = '0;
          statNxt = endStatus(1'b0);
        end
      end
      ST_XFER: begin
        if (paramWr && lastWord) begin
          stateNxt = ST_CHECK;
          statNxt  = '0;
          statNxt[ST_BSY] = 1'b1;
        end
      end
      ST_CHECK: begin
        if (!lockEn_r && !isMaster_r) begin // R4
          stateNxt = ST_IDLE;
          errNxt   = abortErr(1'b0);
          statNxt  = endStatus(1'b1);
        end else if (lockEn_r && !pwMatch_r) begin // R5
          stateNxt = ST_IDLE;
          errNxt   = abortErr(1'b0);
          statNxt  = endStatus(1'b1);
        end else if (enhanced_r) begin // R7
          stateNxt = ST_IDLE;
          errNxt   = abortErr(1'b0);
          statNxt  = endStatus(1'b1);
        end else begin
          stateNxt = ST_WIPE; // R11
        end
      end
      ST_WIPE: begin
        if (wipeFail) begin
          stateNxt = ST_IDLE;
          errNxt   = abortErr(1'b1); // R18
          statNxt  = endStatus(1'b1);
        end else if (lastBlk) begin
          stateNxt = ST_DONE;
        end
      end
      ST_DONE: begin
        stateNxt = ST_IDLE;
        statNxt  = endStatus(1'b0); // R17
      end
      default: stateNxt = ST_IDLE;
    endcase
  end

  // state register and status bytes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r     <= ST_IDLE;
      errFlags_r  <= '0;
      statFlags_r <= STATUS_RESET;
    end else if (clkEn) begin
      state_r     <= stateNxt;
      errFlags_r  <= errNxt;
      statFlags_r <= statNxt;
    end
  end

  // security state; frozen only clears at power-on reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lockEn_r <= 1'b0;
      frozen_r <= 1'b0;
      armed_r  <= 1'b0;
    end else if (clkEn) begin
      if (isFreeze)
        frozen_r <= 1'b1; // R13 R15
      if (state_r == ST_DONE)
        lockEn_r <= 1'b0; // R10
      else if (lockWr && idle && !frozen_r)
        lockEn_r <= hwdata[0]; // R14
      // prepare arms only the very next command
      if (cmdWr && forMe && idle)
        armed_r <= isPrep && !frozen_r; // R9 R16
    end
  end

  // parameter sector capture and running password compare
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wordCnt_r  <= '0;
      isMaster_r <= 1'b0;
      enhanced_r <= 1'b0;
      pwMatch_r  <= 1'b1;
    end else if (clkEn) begin
      if (isErase) begin
        wordCnt_r <= '0;
        pwMatch_r <= 1'b1;
      end else if (paramWr) begin
        wordCnt_r <= wordCnt_r + 9'd1;
        if (wordCnt_r == '0) begin
          isMaster_r <= hwdata[PB_IDENT_BIT];   // R6
          enhanced_r <= hwdata[PB_ENHANCE_BIT]; // R7
        end else if (inPw && hwdata[15:0] != selPw) begin
          pwMatch_r <= 1'b0; // R5 R6
        end
      end
    end
  end

  // stored passwords; the erase never touches the master copy
  always_ff @(posedge sys_clk) begin
    if (clkEn && userPwWr)
      userPw_r[hwdata[19:16]] <= hwdata[15:0];
    if (clkEn && mastPwWr)
      mastPw_r[hwdata[19:16]] <= hwdata[15:0]; // R10
  end

  // zero-fill walk; host maximum is deliberately ignored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wipeBlock_r <= FIRST_BLOCK;
      wipeWrite_r <= 1'b0;
      dataReq_r   <= 1'b0;
    end else if (clkEn) begin
      dataReq_r   <= stateNxt == ST_XFER; // R3
      wipeWrite_r <= stateNxt == ST_WIPE; // R8
      if (state_r == ST_CHECK)
        wipeBlock_r <= FIRST_BLOCK; // R2
      else if (state_r == ST_WIPE && !lastBlk)
        wipeBlock_r <= wipeBlock_r + 32'd1; // R2 R8
    end
  end

  // configuration registers; native maximum only moves between commands
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nativeMax_r <= NATIVE_MAX_DEF;
      hostMax_r   <= NATIVE_MAX_DEF;
      drive_r     <= 1'b0;
    end else if (clkEn) begin
      if (natMaxWr)
        nativeMax_r <= hwdata;
      if (hostMaxWr)
        hostMax_r <= hwdata;
      if (driveWr)
        drive_r <= hwdata[0];
    end
  end

  // fail pin is asynchronous: two stages before the state machine sees it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wipeFailS1_r <= 1'b0;
      wipeFailS2_r <= 1'b0;
    end else if (clkEn) begin
      wipeFailS1_r <= wipeFailPin;
      wipeFailS2_r <= wipeFailS1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped reads return zero
  wire [31:0] rdMux =
    aIdx == ADDR_ERROR  ? {24'h0, errFlags_r} :
    aIdx == ADDR_STATUS ? {24'h0, statFlags_r} :
    aIdx == ADDR_STATE  ? {27'h0, state_r == ST_WIPE, dataReq_r, armed_r,
                           frozen_r, lockEn_r} :
    aIdx == ADDR_LOCKEN ? {31'h0, lockEn_r} :
    aIdx == ADDR_ERTIME ? {16'h0, ERASE_TIME_DEF} : // R12
    aIdx == ADDR_NATMAX ? nativeMax_r :
    aIdx == ADDR_HOSTMX ? hostMax_r :
    aIdx == ADDR_DRIVE  ? {31'h0, drive_r} : 32'h0;

  // zero wait states; write data taken in the data phase
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_r    <= 1'b0;
      wrAddr_r    <= '0;
      rdValid_r   <= 1'b0;
      rdData_r    <= '0;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else if (clkEn) begin
      hresp_r   <= 1'b0; // single word transfers only, always OKAY
      wrPend_r  <= addrPhase && hwrite;
      wrAddr_r  <= aIdx;
      rdValid_r <= addrPhase && !hwrite;
      if (addrPhase && !hwrite)
        rdData_r <= rdMux;
    end
  end

  // every output below is a register, never a decode
  assign hrdata      = rdData_r;
  assign hreadyout   = hreadyout_r;
  assign hresp       = hresp_r;
  assign dataRequest = dataReq_r;
  assign wipeWrite   = wipeWrite_r;
  assign wipeBlock   = wipeBlock_r;
endmodule // security_erase_freeze_cmds

// ===== bench/sec_cmd_assertions.sv
// port-level checks for the secure-erase and freeze command block
`timescale 1ns/1ns
module sec_cmd_checker (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        clkEn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        dataRequest,
  input wire logic        wipeWrite,
  input wire logic [31:0] wipeBlock,
  input wire logic        wipeFailPin
);
  import sec_cmd_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic        take, cmdPh_r, natPh_r, frozen_r;
  logic [7:0]  lastOp_r, prevOp_r;
  logic [31:0] natMax_r;
  ////////////////////////////////////////////////////////////
  // shadow of command history, freeze and native maximum, from bus traffic only
  assign take = hsel && hready && clkEn && htrans == HTRANS_NONSEQ && hwrite;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmdPh_r  <= 1'b0;
      natPh_r  <= 1'b0;
      frozen_r <= 1'b0;
      lastOp_r <= 8'h00;
      prevOp_r <= 8'h00;
      natMax_r <= NATIVE_MAX_DEF;
    end else begin
      cmdPh_r <= take && haddr[7:0] == ADDR_CMD;
      natPh_r <= take && haddr[7:0] == ADDR_NATMAX;
      // data phase carries the opcode; freeze is sticky until reset
      if (cmdPh_r) begin
        lastOp_r <= hwdata[7:0];
        prevOp_r <= lastOp_r;
        frozen_r <= frozen_r || hwdata[7:0] == OP_FREEZE;
      end
      if (natPh_r) begin
        natMax_r <= hwdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // bus answer and wipe sequencing
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_wipe_first; $rose(wipeWrite) |-> wipeBlock == FIRST_BLOCK; endproperty
  a_wipe_first: assert property (p_wipe_first) else $error("wipe not from block 0");
  property p_wipe_step; wipeWrite && $past(wipeWrite) |-> wipeBlock == $past(wipeBlock) + 32'h1;
  endproperty
  a_wipe_step: assert property (p_wipe_step) else $error("wipe block skipped");
  // a media failure legally cuts the walk short, so only a clean walk must reach the end
  property p_wipe_last;
    $fell(wipeWrite) && !wipeFailPin |-> $past(wipeBlock) == natMax_r;
  endproperty
  a_wipe_last: assert property (p_wipe_last) else $error("wipe end not native max");
  property p_req_order;
    $rose(dataRequest) |-> lastOp_r == OP_ERASE_UNIT && prevOp_r == OP_ERASE_PREP;
  endproperty
  a_req_order: assert property (p_req_order) else $error("request without armed erase");
  property p_no_overlap; dataRequest |-> !wipeWrite; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("wipe before sector taken");
  property p_frozen; frozen_r |-> !wipeWrite && !$rose(dataRequest); endproperty
  a_frozen: assert property (p_frozen) else $error("erase ran while frozen");
endmodule // sec_cmd_checker
bind security_erase_freeze_cmds sec_cmd_checker u_chk (.sys_clk, .resetn, .clkEn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .dataRequest, .wipeWrite,
  .wipeBlock, .wipeFailPin);

// ===== bench/host_bus_model.sv
// host controller model: single-word bus master issuing commands and sectors
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  import sec_cmd_pkg::*;
  localparam logic [7:0] DEV_HEAD = 8'((1 << DEVHEAD_B7) | (1 << DEVHEAD_B5));
  // bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  // one transfer; caller enters just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hwdata <= ~hwdata; // released data must not look valid
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    if (wr) hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  // opcode with device/head bits 7 and 5 set, drive 0
  task automatic cmd(input logic [7:0] op);
    logic [31:0] r;
    xfer(1'b1, ADDR_CMD, {16'h0, DEV_HEAD, op}, r);
  endtask
  // exactly one sector: control word, password words, reserved zeros
  task automatic sector(input logic [15:0] w0, input logic [15:0] pw);
    logic [31:0] r;
    logic [15:0] w;
    for (int i = 0; i < PB_WORDS; i++) begin
      w = (i == 0) ? w0 : (i <= PB_PW_LAST) ? pw + 16'(i - PB_PW_FIRST) : 16'h0;
      xfer(1'b1, ADDR_PARAM, {16'h0, w}, r);
    end
  endtask
endmodule // host_bus_model

// ===== bench/security_erase_freeze_cmds_tb_top.sv
// self-checking bench for the secure-erase and freeze command block
`timescale 1ns/1ns
module security_erase_freeze_cmds_tb_top;
  import sec_cmd_pkg::*;
  localparam logic [31:0] ABORT_ERR = 32'h1 << ERR_ABORT_BIT;
  localparam logic [7:0]  FAIL_ERR  = 8'((1 << ERR_ABORT_BIT) | (1 << ERR_IDNF_BIT));
  localparam logic [31:0] OK_ST = {24'h0, STATUS_RESET};
  logic        sys_clk;
  logic        resetn;
  logic        wipeFailPin;
  logic [31:0] rv;
  int          err_total;
  int          checks_done;
  int          wipeCnt;
  wire         hsel, hwrite, hready, hresp, dataRequest, wipeWrite;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  wire  [31:0] haddr, hwdata, hrdata, wipeBlock;
  ////////////////////////////////////////////////////////////
  // clock gate held open so gated state never hides a fault
  host_bus_model host (.sys_clk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  security_erase_freeze_cmds uut (.sys_clk, .resetn, .clkEn(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .dataRequest,
    .wipeWrite, .wipeBlock, .wipeFailPin);
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // zero-write cycles of the current erase
  always @(posedge sys_clk) begin
    if (wipeWrite === 1'b1) wipeCnt <= wipeCnt + 1;
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rv);
    chk(exp, rv);
  endtask
  // prepare, erase, one sector, then poll until not busy
  task automatic runErase(input logic [15:0] w0, input logic [15:0] pw, input logic [7:0] eErr,
                          input int eWipes);
    int n;
    host.cmd(OP_ERASE_PREP);
    host.cmd(OP_ERASE_UNIT);
    wipeCnt = 0;
    n = 0;
    while (dataRequest !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'h1, {31'h0, dataRequest});
    host.sector(w0, pw);
    rv = 32'h80;
    while (rv[ST_BSY] !== 1'b0 && n < 3000) begin
      host.xfer(1'b0, ADDR_STATUS, 32'h0, rv);
      n++;
    end
    chk(OK_ST | {31'h0, eErr != 8'h0}, rv);
    rdChk(ADDR_ERROR, {24'h0, eErr});
    chk(32'(eWipes), 32'(wipeCnt));
  endtask
  task automatic t_idle();
    host.xfer(1'b1, ADDR_DRIVE, 32'h0, rv);
    rdChk(ADDR_STATUS, OK_ST);
    rdChk(ADDR_ERROR, 32'h0);
    rdChk(ADDR_ERTIME, {16'h0, ERASE_TIME_DEF});
    rdChk(ADDR_NATMAX, NATIVE_MAX_DEF);
    rdChk(8'h40, 32'h0);
    host.cmd(OP_ERASE_UNIT);
    rdChk(ADDR_ERROR, ABORT_ERR);
    rdChk(ADDR_STATUS, OK_ST | 32'h1);
  endtask
  // small native max, host max below it, both passwords loaded
  task automatic t_erase();
    host.xfer(1'b1, ADDR_NATMAX, 32'h7, rv);
    host.xfer(1'b1, ADDR_HOSTMX, 32'h2, rv);
    for (int i = 0; i < PW_WORDS; i++) begin
      host.xfer(1'b1, ADDR_USERPW, {12'h0, 4'(i), 16'h1000 + 16'(i)}, rv);
      host.xfer(1'b1, ADDR_MASTPW, {12'h0, 4'(i), 16'h2000 + 16'(i)}, rv);
    end
    runErase(16'h0, 16'h1000, ABORT_ERR[7:0], 0);
    runErase(16'h3, 16'h2000, ABORT_ERR[7:0], 0);
    host.xfer(1'b1, ADDR_LOCKEN, 32'h1, rv);
    rdChk(ADDR_LOCKEN, 32'h1);
    runErase(16'h0, 16'h5000, ABORT_ERR[7:0], 0);
    runErase(16'h1, 16'h1000, ABORT_ERR[7:0], 0);
    runErase(16'h1, 16'h2000, 8'h00, 8);
    rdChk(ADDR_LOCKEN, 32'h0);
    host.xfer(1'b1, ADDR_LOCKEN, 32'h1, rv);
    runErase(16'h1, 16'h2000, 8'h00, 8);
    runErase(16'h1, 16'h7777, 8'h00, 8);
  endtask
  // media failure one cycle into the walk; the two pin stages let three more wipes out
  task automatic t_wipeFail();
    fork
      begin
        wait (wipeWrite === 1'b1);
        @(posedge sys_clk);
        wipeFailPin <= 1'b1;
      end
    join_none
    runErase(16'h1, 16'h0, FAIL_ERR, 4);
    wipeFailPin <= 1'b0;
  endtask
  task automatic t_freeze();
    logic [7:0] ops [4] = '{OP_SET_PW, OP_UNLOCK, OP_DISABLE_PW, OP_ERASE_UNIT};
    host.cmd(OP_FREEZE);
    rdChk(ADDR_STATUS, OK_ST);
    rdChk(ADDR_STATE, 32'h2);
    foreach (ops[i]) begin
      host.cmd(OP_ERASE_PREP);
      host.cmd(ops[i]);
      rdChk(ADDR_ERROR, ABORT_ERR);
    end
    host.xfer(1'b1, ADDR_LOCKEN, 32'h1, rv);
    rdChk(ADDR_LOCKEN, 32'h0);
    rdChk(ADDR_STATE, 32'h2);
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdChk(ADDR_STATE, 32'h0);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    wipeFailPin = 1'b0;
    err_total = 0;
    checks_done = 0;
    wipeCnt = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_idle();
    t_erase();
    t_wipeFail();
    t_freeze();
    results();
  end
  // watchdog, well past the expected run of a few thousand cycles
  initial begin
    #200000;
    err_total++;
    $display("mismatch t=%0t watchdog expired", $time);
    results();
  end
endmodule // security_erase_freeze_cmds_tb_top
